// >>> fpc_pkg.sv
/*
  Shared constants for the flash protection and configuration logic:
  command codes, register bit positions, reset values and frame lengths.
  Assumes a single-lane serial host, mode 0, most significant bit first.
*/
`default_nettype none

package fpc_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_STATUS_WRITE = 8'h01;
  localparam logic [7:0] CMD_PAGE_PROG    = 8'h02;
  localparam logic [7:0] CMD_WRITE_DIS    = 8'h04;
  localparam logic [7:0] CMD_STATUS_READ  = 8'h05;
  localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] CMD_SECT_ERASE   = 8'h20;
  localparam logic [7:0] CMD_FUNC_WRITE   = 8'h42;
  localparam logic [7:0] CMD_FUNC_READ    = 8'h48;
  localparam logic [7:0] CMD_RP_READ      = 8'h61;
  localparam logic [7:0] CMD_INFO_PROG    = 8'h62;
  localparam logic [7:0] CMD_RP_VOL_B     = 8'h63;
  localparam logic [7:0] CMD_RP_PERSIST   = 8'h65;
  localparam logic [7:0] CMD_RP_VOL_A     = 8'hC0;
  localparam logic [7:0] CMD_ERASE_ALL_A  = 8'hC7;
  localparam logic [7:0] CMD_ERASE_ALL_B  = 8'h60;
  localparam logic [7:0] CMD_BLOCK_ERASE  = 8'hD8;
  localparam logic [7:0] CMD_SUSPEND      = 8'h75;
  localparam logic [7:0] CMD_RESUME       = 8'h7A;

  // ---------------------------------------------------------------
  // Register fields and reset values
  // ---------------------------------------------------------------
  localparam int ST_SWD_BIT   = 7;
  localparam int ST_QE_BIT    = 6;
  localparam int ST_BP_LSB    = 2;
  localparam int ST_WEL_BIT   = 1;
  localparam int ST_BUSY_BIT  = 0;
  localparam int FN_RSTDIS_BIT = 0;
  localparam int FN_PROGRAM_SUSPENDED_FLAG_BIT  = 2;
  localparam int FN_ERASE_SUSPENDED_FLAG_BIT  = 3;
  localparam int FN_LOCK_LSB  = 4;
  localparam logic [7:0] FN_OTP_MASK = 8'hF1;
  localparam int RP_PIN_BIT   = 7;
  localparam int RP_WAIT_LSB  = 3;
  localparam int RP_WRAP_BIT  = 2;
  localparam int RP_BURST_LSB = 0;
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [7:0] RP_RESET     = 8'h00;
  localparam int BLOCK_SHIFT  = 16;
  localparam int ROW_LSB      = 8;

  // ---------------------------------------------------------------
  // Frame lengths in serial clock rises
  // ---------------------------------------------------------------
  localparam logic [5:0] LEN_CMD  = 6'h08;
  localparam logic [5:0] LEN_DATA = 6'h10;
  localparam logic [5:0] LEN_ADDR = 6'h20;

  typedef enum logic [1:0] {FPC_OP_NONE, FPC_OP_PROG, FPC_OP_ERASE} fpc_op_e;
  typedef enum logic [1:0] {FPC_IDLE, FPC_CMD, FPC_WRITE, FPC_READ} fpc_frame_e;

endpackage

`default_nettype wire

// >>> fpc_block_guard.sv
/*
  Decodes the four protection bits into a protected flag for one
  64 KB block index. Purely combinational; the caller screens with it unregistered.
*/
`timescale 1ns/1ns
`default_nettype none

module fpc_block_guard #(
  parameter int BLK_W = 6
) (
  input  wire logic [3:0]       protect_code,
  input  wire logic [BLK_W-1:0] block_index,
  output var  logic             is_protected
);
  // ---------------------------------------------------------------
  // Region decode
  // ---------------------------------------------------------------
  localparam logic [BLK_W:0] NUM_BLOCKS = (BLK_W+1)'(1 << BLK_W);
  wire logic [3:0]   top_exp = protect_code - 4'h1;
  wire logic [3:0]   bot_exp = 4'hE - protect_code;
  wire logic [BLK_W:0] top_n = (BLK_W+1)'(1) << top_exp;
  wire logic [BLK_W:0] bot_n = (BLK_W+1)'(1) << bot_exp;
  wire logic [BLK_W:0] idx   = {1'b0, block_index};
  // Top codes cover the high end, bottom codes the low end
  wire logic top_hit = (protect_code >= 4'h1) && (protect_code <= 4'h6)
                       && (idx >= NUM_BLOCKS - top_n);
  wire logic bot_hit = (protect_code >= 4'h9) && (protect_code <= 4'hE)
                       && (idx < bot_n);
  wire logic all_hit = (protect_code == 4'h7) || (protect_code == 4'h8);

  assign is_protected = top_hit | bot_hit | all_hit;

endmodule

`default_nettype wire

// >>> fpc_regs.sv
/*
  Protection and configuration registers of a serial flash, reached
  over the serial pins. Samples the pins with ref_clk (link clock far
  slower), executes writes at chip-select release, answers register
  reads, and screens array program and erase requests.
  Assumes an array engine on ref_clk that reports busy and done.
*/
`timescale 1ns/1ns
`default_nettype none

module fpc_regs
  import fpc_pkg::*;
#(
  parameter int ADDR_W  = 22,
  parameter bit HAS_DED = 1'b1
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        serial_clk_pin,
  input  wire logic        chip_sel_b_pin,
  input  wire logic        data_in_pin,
  input  wire logic        write_protect_b_pin,
  input  wire logic        four_lane_command_mode,
  input  wire logic        array_busy,
  input  wire logic        array_done,
  output var  logic        data_out,
  output var  logic        data_out_oe,
  output var  logic        op_start,
  output var  logic        op_refused,
  output var  fpc_pkg::fpc_op_e op_kind,
  output var  logic        op_info_row,
  output var  logic [23:0] op_addr,
  output var  logic        suspend_req,
  output var  logic        resume_req,
  output var  logic        quad_lanes,
  output var  logic        shared_pin_reset,
  output var  logic        dedicated_reset_on,
  output var  logic [3:0]  wait_cycles,
  output var  logic        wait_use_default,
  output var  logic [5:0]  wrap_mask
);
  import fpc_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic [1:0] edge_prev;

  // Two stages; only pin_sync is looked at by logic
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      // Idle levels (clock low, select high) so no false edge follows reset
      pin_meta  <= 4'h5;
      pin_sync  <= 4'h5;
      edge_prev <= 2'h1;
    end
    else if (clk_en)
    begin
      pin_meta  <= {serial_clk_pin, chip_sel_b_pin, data_in_pin, write_protect_b_pin};
      pin_sync  <= pin_meta;
      edge_prev <= pin_sync[3:2];
    end
  end

  wire logic sck_s   = pin_sync[3];
  wire logic csb_s   = pin_sync[2];
  wire logic din_s   = pin_sync[1];
  wire logic wp_b_s  = pin_sync[0];
  wire logic sck_rise = sck_s & ~edge_prev[1];
  wire logic sck_fall = ~sck_s & edge_prev[1];
  wire logic cs_fall  = ~csb_s & edge_prev[0];
  wire logic cs_rise  = csb_s & ~edge_prev[0];

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  fpc_frame_e  frame;
  logic [5:0]  bit_cnt;
  logic [31:0] shift_in;
  logic [7:0]  cmd;
  logic        wel;
  logic        swd;
  logic        qe;
  logic [3:0]  bp;
  logic [7:0]  function_config;
  logic [7:0]  rp_persist;
  logic [7:0]  read_parameters;
  logic        load_pending;
  fpc_op_e     active_op;
  logic        blk_prot;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  wire logic        fin    = cs_rise & clk_en & (frame != FPC_IDLE);
  wire logic        len8   = bit_cnt == LEN_CMD;
  wire logic        len16  = bit_cnt == LEN_DATA;
  wire logic        len32  = bit_cnt == LEN_ADDR;
  wire logic [7:0]  wdata  = shift_in[7:0];
  wire logic [23:0] waddr  = shift_in[23:0];
  wire logic        idle_ok = fin & ~array_busy;
  wire logic        nv_ok   = idle_ok & wel;
  wire logic        do_write_enable_cmd = idle_ok & len8 & (cmd == CMD_WRITE_ENABLE);
  wire logic        do_wrdi = idle_ok & len8 & (cmd == CMD_WRITE_DIS);
  wire logic        st_cmd  = nv_ok & len16 & (cmd == CMD_STATUS_WRITE);
  wire logic        st_open = ~swd | wp_b_s;
  wire logic        do_st   = st_cmd & st_open;
  wire logic        do_fn   = nv_ok & len16 & (cmd == CMD_FUNC_WRITE);
  wire logic        do_rpnv = nv_ok & len16 & (cmd == CMD_RP_PERSIST);
  wire logic        do_rpv  = fin & len16
                              & ((cmd == CMD_RP_VOL_A) | (cmd == CMD_RP_VOL_B));
  wire logic        is_pp   = len32 & (cmd == CMD_PAGE_PROG);
  wire logic        is_ers  = len32 & ((cmd == CMD_SECT_ERASE) | (cmd == CMD_BLOCK_ERASE));
  wire logic        is_row  = len32 & (cmd == CMD_INFO_PROG);
  wire logic        is_all  = len8 & ((cmd == CMD_ERASE_ALL_A) | (cmd == CMD_ERASE_ALL_B));
  wire logic [1:0]  row_idx = waddr[ROW_LSB +: 2];
  wire logic        row_lock = function_config[FN_LOCK_LSB + row_idx];
  wire logic        arr_req = nv_ok & (is_pp | is_ers | is_row | is_all);
  wire logic        arr_bad = ((is_pp | is_ers) & blk_prot)
                              | (is_row & row_lock)
                              | (is_all & (bp != 4'h0));
  wire logic        grant   = arr_req & ~arr_bad;
  wire logic        refuse  = arr_req & arr_bad;
  wire logic        is_susp = fin & len8 & (cmd == CMD_SUSPEND) & array_busy;
  wire logic        is_res  = fin & len8 & (cmd == CMD_RESUME);
  wire logic        program_suspended_flag_set = is_susp & (active_op == FPC_OP_PROG);
  wire logic        erase_suspended_flag_set = is_susp & (active_op == FPC_OP_ERASE);
  wire logic        program_suspended_flag_clr = is_res & function_config[FN_PROGRAM_SUSPENDED_FLAG_BIT];
  wire logic        erase_suspended_flag_clr = is_res & function_config[FN_ERASE_SUSPENDED_FLAG_BIT]
                               & ~function_config[FN_PROGRAM_SUSPENDED_FLAG_BIT];
  wire logic        is_read = (cmd == CMD_STATUS_READ) | (cmd == CMD_FUNC_READ)
                              | (cmd == CMD_RP_READ);
  wire logic [7:0]  next_cmd = {shift_in[6:0], din_s};

  // Block index sits above the 64 KB boundary
  fpc_block_guard #(
    .BLK_W        (ADDR_W - BLOCK_SHIFT)
  ) u_guard (
    .protect_code (bp),
    .block_index  (waddr[ADDR_W-1:BLOCK_SHIFT]),
    .is_protected (blk_prot)
  );

  // Readback selection; reads repeat the live value each byte
  wire logic [7:0] status_byte = {swd, qe, bp, wel, array_busy};
  wire logic [7:0] rd_byte = (cmd == CMD_STATUS_READ) ? status_byte
                           : (cmd == CMD_FUNC_READ) ? function_config
                           : read_parameters;
  wire logic [2:0] rd_bit = 3'h7 - bit_cnt[2:0];

  // Function register next value: one-time bits only ever set
  wire logic [7:0] fn_otp_next = function_config | (wdata & FN_OTP_MASK);
  wire logic [7:0] next_fn = {do_fn ? fn_otp_next[7:4] : function_config[7:4],
                              (function_config[FN_ERASE_SUSPENDED_FLAG_BIT] | erase_suspended_flag_set) & ~erase_suspended_flag_clr,
                              (function_config[FN_PROGRAM_SUSPENDED_FLAG_BIT] | program_suspended_flag_set) & ~program_suspended_flag_clr,
                              1'b0,
                              do_fn ? fn_otp_next[0] : function_config[0]};

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  // A frame opens at chip-select fall and shifts on clock rises
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      frame    <= FPC_IDLE;
      bit_cnt  <= 6'h00;
      shift_in <= 32'h0000_0000;
      cmd      <= 8'h00;
    end
    else if (clk_en)
    begin
      unique case (frame)
        FPC_IDLE:
        begin
          if (cs_fall)
          begin
            frame   <= FPC_CMD;
            bit_cnt <= 6'h00;
          end
        end
        FPC_CMD, FPC_WRITE, FPC_READ:
        begin
          if (cs_rise)
            frame <= FPC_IDLE;
          else if (sck_rise)
          begin
            shift_in <= {shift_in[30:0], din_s};
            if (bit_cnt != 6'h3F)
              bit_cnt <= bit_cnt + 6'h01;                            // Saturates on long frames
            if (frame == FPC_CMD && bit_cnt == 6'h07)
            begin
              cmd   <= next_cmd;
              frame <= ((next_cmd == CMD_STATUS_READ) || (next_cmd == CMD_FUNC_READ)
                        || (next_cmd == CMD_RP_READ)) ? FPC_READ : FPC_WRITE;
            end
          end
        end
      endcase
    end
  end

  // Read data launched on the falling edge, ready for the next rise
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      data_out    <= 1'b0;
      data_out_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      data_out_oe <= (frame == FPC_READ) & ~csb_s & is_read;
      if (frame == FPC_READ && sck_fall)
        data_out <= rd_byte[rd_bit];
    end
  end

  // ---------------------------------------------------------------
  // Status, function and read parameter registers
  // ---------------------------------------------------------------
  // Status bits 7:2 only move on an accepted status write
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {swd, qe, bp} <= STATUS_RESET;
      wel           <= 1'b0;
    end
    else if (clk_en)
    begin
      if (do_st)
        {swd, qe, bp} <= wdata[7:2];
      if (do_write_enable_cmd)
        wel <= 1'b1;
      else if (do_wrdi | do_st | do_fn | do_rpnv | grant)
        wel <= 1'b0;
    end
  end

  // Bit 0 default follows whether the part has a dedicated reset pin
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
      function_config <= {7'h00, ~HAS_DED};
    else if (clk_en)
      function_config <= next_fn;
  end

  // Volatile copy takes the persistent copy once after power-up
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rp_persist      <= RP_RESET;
      read_parameters <= RP_RESET;
      load_pending    <= 1'b1;
    end
    else if (clk_en)
    begin
      load_pending <= 1'b0;
      if (load_pending)
        read_parameters <= rp_persist;
      else if (do_rpv)
        read_parameters <= wdata;
      if (do_rpnv)
        rp_persist <= wdata;
    end
  end

  // ---------------------------------------------------------------
  // Array operation screening and suspend tracking
  // ---------------------------------------------------------------
  // The engine's done pulse ends the tracked operation
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      active_op   <= FPC_OP_NONE;
      op_start    <= 1'b0;
      op_refused  <= 1'b0;
      op_kind     <= FPC_OP_NONE;
      op_info_row <= 1'b0;
      op_addr     <= 24'h00_0000;
      suspend_req <= 1'b0;
      resume_req  <= 1'b0;
    end
    else if (clk_en)
    begin
      op_start    <= grant;
      op_refused  <= refuse;
      suspend_req <= program_suspended_flag_set | erase_suspended_flag_set;
      resume_req  <= program_suspended_flag_clr | erase_suspended_flag_clr;
      if (grant)
      begin
        active_op   <= (is_pp | is_row) ? FPC_OP_PROG : FPC_OP_ERASE;
        op_kind     <= (is_pp | is_row) ? FPC_OP_PROG : FPC_OP_ERASE;
        op_info_row <= is_row;
        op_addr     <= is_all ? 24'h00_0000 : waddr;
      end
      else if (array_done)
        active_op <= FPC_OP_NONE;
    end
  end

  // ---------------------------------------------------------------
  // Pin roles and read configuration outputs
  // ---------------------------------------------------------------
  wire logic single_lane = ~qe & ~four_lane_command_mode;
  wire logic ded_live    = HAS_DED & ~function_config[FN_RSTDIS_BIT];
  // Dedicated pin still live forces hold; disabled pin moves reset over only in single-lane mode
  wire logic next_shared_reset = single_lane & ~ded_live
                                 & (function_config[FN_RSTDIS_BIT]
                                    | read_parameters[RP_PIN_BIT]);
  wire logic [1:0] burst = read_parameters[RP_BURST_LSB +: 2];
  wire logic [5:0] burst_mask = (6'h08 << burst) - 6'h01;
  wire logic [3:0] wait_field = read_parameters[RP_WAIT_LSB +: 4];

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      quad_lanes         <= 1'b0;
      shared_pin_reset   <= 1'b0;
      dedicated_reset_on <= HAS_DED;
      wait_cycles        <= 4'h0;
      wait_use_default   <= 1'b1;
      wrap_mask          <= 6'h00;
    end
    else if (clk_en)
    begin
      quad_lanes         <= qe;
      shared_pin_reset   <= next_shared_reset;
      dedicated_reset_on <= ded_live;
      wait_cycles        <= wait_field;
      wait_use_default   <= wait_field == 4'h0;
      wrap_mask          <= read_parameters[RP_WRAP_BIT] ? burst_mask : 6'h00;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  a_otp_sticky: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> ((($past(function_config) & FN_OTP_MASK) & ~function_config) == 8'h00))
    else $error("one-time function bit cleared");

  a_rsvd_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    function_config[1] == 1'b0)
    else $error("reserved function bit set");

  a_erase_all_bp: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (fin & is_all & (bp != 4'h0)) |=> !op_start)
    else $error("whole-array erase started with protection set");

  a_status_locked: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_cmd & swd & ~wp_b_s) |=> ({swd, qe, bp} == $past({swd, qe, bp})))
    else $error("locked status bits changed");

  a_status_taken: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (st_cmd & (~swd | wp_b_s)) |=> ({swd, qe, bp} == $past(wdata[7:2])))
    else $error("status write not taken");

  a_block_refuse: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (nv_ok & (is_pp | is_ers) & blk_prot) |=> (op_refused & !op_start))
    else $error("protected block not refused");

  a_row_lock: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (nv_ok & is_row & row_lock) |=> (op_refused & !op_start))
    else $error("locked row programmed");

  a_quad_lanes: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en |=> (quad_lanes == $past(qe)))
    else $error("lane role does not follow quad enable");

  a_program_suspended_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_b)
    program_suspended_flag_set |=> function_config[FN_PROGRAM_SUSPENDED_FLAG_BIT] & suspend_req)
    else $error("program suspend flag not set");

  a_vol_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (load_pending & clk_en) |=> (read_parameters == $past(rp_persist)))
    else $error("volatile copy not loaded");

endmodule

`default_nettype wire

// >>> fpc_host_model.sv
/*
  Host model: sends serial frames, mode 0, most significant bit first.
  Assumes the bench calls xfer at a falling ref_clk edge.
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_host_model (
  input  wire logic ref_clk,
  input  wire logic data_out,
  output var  logic serial_clk_pin,
  output var  logic chip_sel_b_pin,
  output var  logic data_in_pin
);
  // Clock idles low between frames
  initial
  begin
    serial_clk_pin = 1'b0;
    chip_sel_b_pin = 1'b1;
    data_in_pin    = 1'b0;
  end

  // One frame; about 130 ns per bit, read bits taken at each rise
  task automatic xfer(input int n, input logic [31:0] v, output logic [7:0] rd);
    chip_sel_b_pin = 1'b0;
    repeat (4) @(negedge ref_clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      data_in_pin = v[i];
      repeat (6) @(negedge ref_clk);
      serial_clk_pin = 1'b1;
      rd = {rd[6:0], data_out};
      repeat (7) @(negedge ref_clk);
      serial_clk_pin = 1'b0;
    end
    repeat (4) @(negedge ref_clk);
    chip_sel_b_pin = 1'b1;
    data_in_pin = ~data_in_pin; // Released line must not keep its value
    repeat (8) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// >>> fpc_regs_tb.sv
/*
  Bench for fpc_regs: frames from fpc_host_model, checks at the ports.
  Assumes the default parameters (dedicated reset pin present).
*/
`timescale 1ns/1ns
`default_nettype none
module fpc_regs_tb;
  import fpc_pkg::*;
  logic ref_clk, rst_b, wp_b, busy, done, sclk, cs_b, din, dout, oe;
  logic start, refused, info, sus, res, quad, shr, ded, wdef;
  fpc_op_e kind;
  logic [23:0] addr;
  logic [3:0] waitc;
  logic [5:0] wmask;
  logic [7:0] rd;
  logic st_start, st_ref, st_sus, st_res, st_oe, four_lane;
  int err_count, check_count;

  fpc_host_model host_i (.ref_clk(ref_clk), .data_out(dout), .serial_clk_pin(sclk),
    .chip_sel_b_pin(cs_b), .data_in_pin(din));
  fpc_regs fpc_regs_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(1'b1),
    .serial_clk_pin(sclk), .chip_sel_b_pin(cs_b), .data_in_pin(din),
    .write_protect_b_pin(wp_b), .four_lane_command_mode(four_lane), .array_busy(busy),
    .array_done(done), .data_out(dout), .data_out_oe(oe), .op_start(start),
    .op_refused(refused), .op_kind(kind), .op_info_row(info), .op_addr(addr),
    .suspend_req(sus), .resume_req(res), .quad_lanes(quad), .shared_pin_reset(shr),
    .dedicated_reset_on(ded), .wait_cycles(waitc), .wait_use_default(wdef),
    .wrap_mask(wmask));

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Pulses last one cycle, so hold them for the checks
  always @(posedge ref_clk)
  begin
    st_start <= st_start | start;
    st_ref   <= st_ref | refused;
    st_sus   <= st_sus | sus;
    st_res   <= st_res | res;
    st_oe    <= st_oe | oe;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c);
    host_i.xfer(8, {24'h0, c}, rd);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    host_i.xfer(16, {16'h0, c, d}, rd);
  endtask
  task automatic pw(input logic [7:0] c, input logic [7:0] d);
    cmd(CMD_WRITE_ENABLE);
    wr(c, d);
  endtask
  task automatic rdchk(input logic [7:0] c, input logic [7:0] exp);
    st_oe = 1'b0;
    wr(c, 8'h00);
    chk({st_oe, rd}, {1'b1, exp});
  endtask
  task automatic op(input int n, input logic [31:0] v);
    cmd(CMD_WRITE_ENABLE);
    st_start = 1'b0;
    st_ref = 1'b0;
    st_sus = 1'b0;
    st_res = 1'b0;
    host_i.xfer(n, v, rd);
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Watchdog: a hang ends the run as a failure
  initial
  begin
    #900000;
    err_count++;
    stop_test();
  end

  // Main sequence
  initial
  begin
    {rst_b, busy, done, st_start, st_ref, st_sus, st_res, st_oe, four_lane} = 9'h000;
    wp_b = 1'b1;
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(wdef, 1'b1);
    chk(wmask, 6'h00);
    rdchk(CMD_RP_READ, 8'h00);
    for (int b = 0; b < 4; b++)
    begin
      wr(b[0] ? CMD_RP_VOL_B : CMD_RP_VOL_A, {1'b1, 4'(b + 1), 1'b1, 2'(b)});
      chk(wmask, 8'((8 << b) - 1));
      chk(waitc, 4'(b + 1));
      chk(wdef, 1'b0);
      chk({ded, shr}, 2'b10);
      rdchk(CMD_RP_READ, {1'b1, 4'(b + 1), 1'b1, 2'(b)});
    end
    wr(CMD_RP_VOL_A, 8'h7B);
    chk({waitc, 2'b00, wmask}, 12'hF00);
    wr(CMD_STATUS_WRITE, 8'h04);
    rdchk(CMD_STATUS_READ, 8'h00);
    pw(CMD_STATUS_WRITE, 8'h04);
    rdchk(CMD_STATUS_READ, 8'h04);
    op(32, {CMD_SECT_ERASE, 24'h3F0000});
    chk({st_start, st_ref}, 2'b01);
    // Erase then program: grant, suspend, resume, engine done
    for (int k = 0; k < 2; k++)
    begin
      op(32, k ? {CMD_PAGE_PROG, 24'h000100} : {CMD_BLOCK_ERASE, 24'h3E0000});
      chk({st_start, st_ref, info, 5'(kind), addr}, {2'b10, 1'b0,
        k ? 5'(FPC_OP_PROG) : 5'(FPC_OP_ERASE), k ? 24'h000100 : 24'h3E0000});
      busy = 1'b1;
      cmd(CMD_SUSPEND);
      rdchk(CMD_FUNC_READ, k ? 8'h04 : 8'h08);
      cmd(CMD_RESUME);
      rdchk(CMD_FUNC_READ, 8'h00);
      chk({st_sus, st_res}, 2'b11);
      {busy, done} = 2'b01;
      @(negedge ref_clk);
      done = 1'b0;
    end
    op(8, {24'h0, CMD_ERASE_ALL_B});
    chk({st_start, st_ref}, 2'b01);
    pw(CMD_FUNC_WRITE, 8'h13);
    rdchk(CMD_FUNC_READ, 8'h11);
    chk({ded, shr}, 2'b01);
    four_lane = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk(shr, 1'b0);
    four_lane = 1'b0;
    pw(CMD_FUNC_WRITE, 8'h00);
    rdchk(CMD_FUNC_READ, 8'h11);
    op(32, {CMD_INFO_PROG, 24'h000000});
    chk({st_start, st_ref}, 2'b01);
    op(32, {CMD_INFO_PROG, 24'h000200});
    chk({st_start, st_ref, info}, 3'b101);
    pw(CMD_STATUS_WRITE, 8'hC0);
    chk({quad, shr}, 2'b10);
    wp_b = 1'b0;
    pw(CMD_STATUS_WRITE, 8'h00);
    wr(CMD_STATUS_READ, 8'h00);
    chk(rd & 8'hFC, 8'hC0);
    wp_b = 1'b1;
    pw(CMD_STATUS_WRITE, 8'h00);
    chk(quad, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
